//--- prc_reset_control.sv
// Summary of operation
// - Low fundamental reset drives internal link reset
// - Fundamental reset clears non-sticky bits, machines
// - Fundamental release latches static straps, EEPROM presence
// - After release, start download, then link setup
// - Link training starts within 80 ms
// - Hot reset moves link into DL_DOWN
// - DL_DOWN clears all but sticky, loadable bits
// - Fundamental or hot reset asserts PCI bus reset
// - Sticky bits clear only on global/power-on
// - Loadable bits clear on fundamental, global, power-on
// - Bridge control bit 6 drives PCI bus reset
// - Only 100 MHz common differential reference supported
// - No beacon, wake or auxiliary power support
// - Global reset low forces power-on reset on the next clock edge
// - Power-on release 10 us after clock activity
`timescale 1ns/10ps
module prc_reset_control import prc_pkg::*; #(
  parameter int TRAIN_LIMIT = TRAIN_LIMIT_CYCLES
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Reset pins and power monitors
  input wire logic fundamental_reset_n,
  input wire logic global_reset_n,
  input wire logic power_good,
  input wire logic diff_ref_clock_active,
  input wire logic [STRAP_WIDTH-1:0] strap_pins,
  input wire logic eeprom_present,
  // Link layer
  input wire logic hot_reset_active,
  output logic link_training,
  output logic wake_oe,
  // EEPROM loader
  output logic eeprom_start,
  input wire logic eeprom_done,
  input wire logic eeprom_data_valid,
  input wire logic [15:0] eeprom_data,
  // Configuration access
  input wire logic cfg_write,
  input wire logic cfg_read,
  input wire logic [7:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  output logic [15:0] cfg_rdata,
  // Reset outputs to the device
  output logic nonsticky_reset,
  output logic eeprom_class_reset,
  output logic sticky_reset,
  output logic pci_bus_reset_n,
  output logic [STRAP_WIDTH-1:0] strap_latched
);

  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [1:0] gr_sync_ff;
  logic [1:0] fr_sync_ff;
  logic [1:0] pg_sync_ff;
  logic [1:0] rc_sync_ff;
  logic [1:0] ep_sync_ff;
  logic [STRAP_WIDTH-1:0] st_meta_ff;
  logic [STRAP_WIDTH-1:0] st_sync_ff;

  // Global reset clears its chain at once, release is synchronous
  always_ff @(posedge clock or negedge global_reset_n) begin
    if (!global_reset_n) begin
      gr_sync_ff <= 2'b00;
    end else begin
      gr_sync_ff <= {gr_sync_ff[0], 1'b1};
    end
  end

  // Two-stage capture of the remaining pins
  always_ff @(posedge clock) begin
    fr_sync_ff <= {fr_sync_ff[0], fundamental_reset_n};
    pg_sync_ff <= {pg_sync_ff[0], power_good};
    rc_sync_ff <= {rc_sync_ff[0], diff_ref_clock_active};
    ep_sync_ff <= {ep_sync_ff[0], eeprom_present};
    st_meta_ff <= strap_pins;
    st_sync_ff <= st_meta_ff;
  end

  // ************************************************************
  // Timers
  // ************************************************************
  prc_timer_if por_tif ();
  prc_timer_if train_tif ();

  prc_timer #(.LIMIT(POR_SETTLE_CYCLES)) u_por_timer (
    .clock(clock),
    .reset_n(reset_n),
    .tif(por_tif)
  );

  prc_timer #(.LIMIT(TRAIN_LIMIT - TRAIN_MARGIN_CYCLES)) u_train_timer (
    .clock(clock),
    .reset_n(reset_n),
    .tif(train_tif)
  );

  // ************************************************************
  // Reset classes and sequencing
  // ************************************************************
  prc_link_state_e state_ff;
  prc_link_state_e nxt_state;
  logic por_done_ff;
  logic nxt_por_done;
  logic fr_prev_ff;
  logic eeprom_present_ff;
  logic nxt_eeprom_present;
  logic [STRAP_WIDTH-1:0] strap_ff;
  logic [STRAP_WIDTH-1:0] nxt_strap;
  logic eeprom_start_ff;
  logic nxt_eeprom_start;
  logic por_active;
  logic fund_active;
  logic fund_rise;
  logic hot_clear;
  logic nonsticky_clear;
  logic eeprom_clear;

  // Power-on reset holds until power, clock and settle time are met
  assign por_active = !por_done_ff;
  assign por_tif.run = gr_sync_ff[1] && pg_sync_ff[1] && rc_sync_ff[1] && !por_done_ff;
  assign fund_active = !fr_sync_ff[1];
  assign fund_rise = fr_sync_ff[1] && !fr_prev_ff;
  assign hot_clear = (state_ff == LS_DL_DOWN);
  assign nonsticky_clear = por_active || fund_active || hot_clear;
  assign eeprom_clear = por_active || fund_active;
  assign train_tif.run = (state_ff == LS_DOWNLOAD);

  // Next state of the sequencer and latched straps
  always_comb begin
    nxt_state = state_ff;
    nxt_strap = strap_ff;
    nxt_eeprom_present = eeprom_present_ff;
    nxt_eeprom_start = 1'b0;
    nxt_por_done = por_done_ff;
    if (!gr_sync_ff[1]) begin
      nxt_por_done = 1'b0;
    end else if (por_tif.expired) begin
      nxt_por_done = 1'b1;
    end
    if (por_active || fund_active) begin
      nxt_state = LS_RESET;
    end else begin
      case (state_ff)
        LS_RESET: begin
          if (fund_rise) begin
            nxt_strap = st_sync_ff;
            nxt_eeprom_present = ep_sync_ff[1];
            nxt_eeprom_start = ep_sync_ff[1];
            nxt_state = LS_DOWNLOAD;
          end
        end
        LS_DOWNLOAD: begin
          if (hot_reset_active) begin
            nxt_state = LS_DL_DOWN;
          end else if (!eeprom_present_ff || eeprom_done || train_tif.expired) begin
            nxt_state = LS_TRAIN;
          end
        end
        LS_TRAIN: begin
          if (hot_reset_active) begin
            nxt_state = LS_DL_DOWN;
          end
        end
        LS_DL_DOWN: begin
          if (!hot_reset_active) begin
            nxt_state = LS_TRAIN;
          end
        end
        default: nxt_state = LS_RESET;
      endcase
    end
  end

  // Register the sequencer
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      state_ff <= LS_RESET;
      strap_ff <= '0;
      eeprom_present_ff <= 1'b0;
      eeprom_start_ff <= 1'b0;
      por_done_ff <= 1'b0;
      fr_prev_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      strap_ff <= nxt_strap;
      eeprom_present_ff <= nxt_eeprom_present;
      eeprom_start_ff <= nxt_eeprom_start;
      por_done_ff <= nxt_por_done;
      fr_prev_ff <= fr_sync_ff[1];
    end
  end

  // ************************************************************
  // Configuration registers
  // ************************************************************
  logic [15:0] bridge_control_ff;
  logic [15:0] nxt_bridge_control;
  logic [15:0] sticky_ff;
  logic [15:0] nxt_sticky;
  logic [15:0] eeload_ff;
  logic [15:0] nxt_eeload;
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;
  logic bus_reset_n_ff;
  logic nxt_bus_reset_n;
  logic [2:0] class_ff;
  logic [2:0] nxt_class;

  // Writes, per-class clearing, reads and bus reset merge
  always_comb begin
    nxt_bridge_control = bridge_control_ff;
    nxt_sticky = sticky_ff;
    nxt_eeload = eeload_ff;
    nxt_rdata = rdata_ff;
    if (nonsticky_clear) begin
      nxt_bridge_control = BRIDGE_CONTROL_RESET;
    end else if (cfg_write && cfg_addr == BRIDGE_CONTROL_OFFSET) begin
      nxt_bridge_control = cfg_wdata;
    end
    if (por_active) begin
      nxt_sticky = STICKY_SCRATCH_RESET;
    end else if (cfg_write && cfg_addr == STICKY_SCRATCH_OFFSET) begin
      nxt_sticky = cfg_wdata;
    end
    if (eeprom_clear) begin
      nxt_eeload = EEPROM_DEFAULTS_RESET;
    end else if (eeprom_data_valid && state_ff == LS_DOWNLOAD) begin
      nxt_eeload = eeprom_data;
    end else if (cfg_write && !hot_clear && cfg_addr == EEPROM_DEFAULTS_OFFSET) begin
      nxt_eeload = cfg_wdata;
    end
    if (cfg_read) begin
      case (cfg_addr)
        BRIDGE_CONTROL_OFFSET: nxt_rdata = bridge_control_ff;
        STICKY_SCRATCH_OFFSET: nxt_rdata = sticky_ff;
        EEPROM_DEFAULTS_OFFSET: nxt_rdata = eeload_ff;
        RESET_STATUS_OFFSET: begin
          nxt_rdata = {6'h00, eeprom_present_ff, link_training, strap_ff, 2'b00, state_ff};
        end
        default: nxt_rdata = 16'h0000;
      endcase
    end
    nxt_bus_reset_n = !(por_active || !gr_sync_ff[1] || fund_active || hot_clear
                        || bridge_control_ff[SECONDARY_BUS_RESET_BIT]);
    nxt_class = {por_active, eeprom_clear, nonsticky_clear};
  end

  // Register configuration state; bus reset releases on the clock
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      bridge_control_ff <= BRIDGE_CONTROL_RESET;
      sticky_ff <= STICKY_SCRATCH_RESET;
      eeload_ff <= EEPROM_DEFAULTS_RESET;
      rdata_ff <= 16'h0000;
      bus_reset_n_ff <= 1'b0;
      class_ff <= 3'h7;
    end else begin
      bridge_control_ff <= nxt_bridge_control;
      sticky_ff <= nxt_sticky;
      eeload_ff <= nxt_eeload;
      rdata_ff <= nxt_rdata;
      bus_reset_n_ff <= nxt_bus_reset_n;
      class_ff <= nxt_class;
    end
  end

  // Outputs
  assign cfg_rdata = rdata_ff;
  assign pci_bus_reset_n = bus_reset_n_ff;
  assign nonsticky_reset = class_ff[0];
  assign eeprom_class_reset = class_ff[1];
  assign sticky_reset = class_ff[2];
  assign link_training = (state_ff == LS_TRAIN);
  assign eeprom_start = eeprom_start_ff;
  assign strap_latched = strap_ff;
  assign wake_oe = 1'b0;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge clock); endclocking
  default disable iff (!reset_n);

  logic [19:0] wait_cnt_ff;
  always_ff @(posedge clock) begin
    if (!reset_n || state_ff != LS_DOWNLOAD) begin
      wait_cnt_ff <= 20'h00000;
    end else begin
      wait_cnt_ff <= wait_cnt_ff + 20'h00001;
    end
  end

  sequence s_sw_set;
    cfg_write && cfg_addr == BRIDGE_CONTROL_OFFSET && cfg_wdata[SECONDARY_BUS_RESET_BIT]
      && !nonsticky_clear;
  endsequence
  sequence s_bus_low;
    ##2 !pci_bus_reset_n;
  endsequence

  property p_fund_clears;
    fund_active |=> bridge_control_ff == BRIDGE_CONTROL_RESET && state_ff == LS_RESET;
  endproperty
  a_fund_clears: assert property (p_fund_clears) else $error("control not cleared");
  property p_fund_bus;
    fund_active |=> !pci_bus_reset_n && nonsticky_reset;
  endproperty
  a_fund_bus: assert property (p_fund_bus) else $error("bus reset missing");
  property p_strap;
    state_ff == LS_RESET && !por_active && fund_rise |=> strap_ff == $past(st_sync_ff);
  endproperty
  a_strap: assert property (p_strap) else $error("straps not latched");
  property p_download;
    state_ff == LS_RESET && !por_active && fund_rise && ep_sync_ff[1]
      |=> eeprom_start && state_ff == LS_DOWNLOAD;
  endproperty
  a_download: assert property (p_download) else $error("download not started");
  property p_deadline;
    wait_cnt_ff < 20'(TRAIN_LIMIT);
  endproperty
  a_deadline: assert property (p_deadline) else $error("training too late");
  property p_hot;
    hot_reset_active && !eeprom_clear && state_ff != LS_RESET |=> state_ff == LS_DL_DOWN;
  endproperty
  a_hot: assert property (p_hot) else $error("no DL_DOWN");
  property p_hot_keeps;
    hot_clear && !eeprom_clear |=> $stable(sticky_ff) && $stable(eeload_ff)
      && bridge_control_ff == BRIDGE_CONTROL_RESET && !pci_bus_reset_n;
  endproperty
  a_hot_keeps: assert property (p_hot_keeps) else $error("hot reset class wrong");
  property p_sticky;
    !por_active && $past(!por_active) && !$past(cfg_write) |-> $stable(sticky_ff);
  endproperty
  a_sticky: assert property (p_sticky) else $error("sticky lost");
  property p_sw;
    s_sw_set |-> s_bus_low;
  endproperty
  a_sw: assert property (p_sw) else $error("software bus reset missing");
  property p_por;
    $rose(por_done_ff) |-> $past(rc_sync_ff[1], 1) && $past(pg_sync_ff[1], 1);
  endproperty
  a_por: assert property (p_por) else $error("power-on released early");
  property p_gr;
    !gr_sync_ff[1] |=> por_active ##1 sticky_ff == STICKY_SCRATCH_RESET;
  endproperty
  a_gr: assert property (p_gr) else $error("global reset ignored");
  property p_wake;
    !wake_oe;
  endproperty
  a_wake: assert property (p_wake) else $error("wake driven");
endmodule

//--- prc_pkg.sv
package prc_pkg;

  // ************************************************************
  // Register map
  // ************************************************************
  localparam logic [7:0] BRIDGE_CONTROL_OFFSET = 8'h3e;
  localparam logic [7:0] STICKY_SCRATCH_OFFSET = 8'h40;
  localparam logic [7:0] EEPROM_DEFAULTS_OFFSET = 8'h44;
  localparam logic [7:0] RESET_STATUS_OFFSET = 8'h48;
  localparam int SECONDARY_BUS_RESET_BIT = 6;
  localparam logic [15:0] BRIDGE_CONTROL_RESET = 16'h0000;
  localparam logic [15:0] STICKY_SCRATCH_RESET = 16'h0000;
  localparam logic [15:0] EEPROM_DEFAULTS_RESET = 16'h0000;
  localparam int STRAP_WIDTH = 4;

  // ************************************************************
  // Timing
  // ************************************************************
  localparam longint CLOCK_HZ = 10000000;
  localparam longint POR_SETTLE_US = 10;
  localparam int POR_SETTLE_CYCLES = int'((POR_SETTLE_US * CLOCK_HZ + 999999) / 1000000);
  localparam longint TRAIN_LIMIT_MS = 80;
  localparam int TRAIN_LIMIT_CYCLES = int'((TRAIN_LIMIT_MS * CLOCK_HZ) / 1000);
  localparam int TRAIN_MARGIN_CYCLES = 8;

  // ************************************************************
  // Link sequencing states
  // ************************************************************
  typedef enum logic [1:0] {
    LS_RESET,
    LS_DOWNLOAD,
    LS_TRAIN,
    LS_DL_DOWN
  } prc_link_state_e;

endpackage

//--- prc_timer_if.sv
`timescale 1ns/10ps
interface prc_timer_if;
  logic run;
  logic expired;
  modport timer (input run, output expired);
  modport user (output run, input expired);
endinterface

//--- prc_timer.sv
`timescale 1ns/10ps
module prc_timer #(
  parameter int unsigned LIMIT = 100
) (
  // Clock and reset
  input wire logic clock,
  input wire logic reset_n,
  // Control
  prc_timer_if.timer tif
);
  localparam int W = $clog2(LIMIT + 1);

  logic [W-1:0] count_ff;
  logic [W-1:0] nxt_count;
  logic expired_ff;
  logic nxt_expired;

  // Count while run is held, restart when it drops
  always_comb begin
    nxt_count = count_ff;
    nxt_expired = expired_ff;
    if (!tif.run) begin
      nxt_count = '0;
      nxt_expired = 1'b0;
    end else if (!expired_ff) begin
      if (count_ff == W'(LIMIT - 1)) begin
        nxt_expired = 1'b1;
      end else begin
        nxt_count = count_ff + 1'b1;
      end
    end
  end

  // Register the counter
  always_ff @(posedge clock) begin
    if (!reset_n) begin
      count_ff <= '0;
      expired_ff <= 1'b0;
    end else begin
      count_ff <= nxt_count;
      expired_ff <= nxt_expired;
    end
  end

  assign tif.expired = expired_ff;
endmodule

//--- prc_host_model.sv
`timescale 1ns/10ps
// ************************************************************
// Upstream port model: reset pin, power and hot reset
// ************************************************************
module prc_host_model (
  // Clock
  input wire logic clock,
  // Reset pins and power monitors
  output logic fundamental_reset_n,
  output logic global_reset_n,
  output logic power_good,
  output logic diff_ref_clock_active,
  // Link layer
  output logic hot_reset_active
);
  // Power-up state: both resets held low, supply and reference present
  initial begin
    fundamental_reset_n = 1'b0;
    global_reset_n = 1'b0;
    power_good = 1'b1;
    diff_ref_clock_active = 1'b1; // Common 100 MHz reference modelled as running
    hot_reset_active = 1'b0;
  end

  // Pin drivers, changed just after a rising edge
  task automatic set_fund(input logic v);
    @(posedge clock);
    fundamental_reset_n <= v;
  endtask

  task automatic set_global_reset_n(input logic v);
    @(posedge clock);
    global_reset_n <= v;
  endtask

  task automatic set_hot(input logic v);
    @(posedge clock);
    hot_reset_active <= v;
  endtask

  // Supply and reference activity, changed together after an edge
  task automatic set_power(input logic pg, input logic rc);
    @(posedge clock);
    power_good <= pg;
    diff_ref_clock_active <= rc;
  endtask

  // Power down: reset pin first, then reference clock, then supply
  task automatic power_down();
    set_fund(1'b0);
    repeat (2) @(posedge clock);
    diff_ref_clock_active <= 1'b0;
    @(posedge clock);
    power_good <= 1'b0;
  endtask
endmodule

//--- prc_reset_control_tb_top.sv
`timescale 1ns/10ps
// ************************************************************
// Self-checking bench for the reset controller
// ************************************************************
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_count++; \
  $display("MISMATCH %0t got %h exp %h", $time, g, e); end end
`define WAITV(s, v, n) for (int w = 0; w < (n) && (s) !== (v); w++) begin \
  @(posedge clock); #1; end
module prc_reset_control_tb_top import prc_pkg::*;;
  localparam int TRAIN_LIMIT = 40;
  logic clock = 1'b0;
  logic reset_n = 1'b0;
  logic fundamental_reset_n, global_reset_n, power_good, diff_ref_clock_active;
  logic hot_reset_active;
  logic [STRAP_WIDTH-1:0] strap_pins;
  logic eeprom_present;
  logic eeprom_done;
  logic eeprom_data_valid;
  logic [15:0] eeprom_data;
  logic cfg_write;
  logic cfg_read;
  logic [7:0] cfg_addr;
  logic [15:0] cfg_wdata;
  logic [15:0] cfg_rdata;
  logic link_training, wake_oe, eeprom_start, pci_bus_reset_n;
  logic nonsticky_reset, eeprom_class_reset, sticky_reset;
  logic [STRAP_WIDTH-1:0] strap_latched;
  int err_count = 0;
  int num_checks = 0;

  // Clock, 100 ns period
  initial begin
    forever #50 clock = ~clock;
  end

  // Upstream port model
  prc_host_model host (.clock(clock), .fundamental_reset_n(fundamental_reset_n),
    .global_reset_n(global_reset_n), .power_good(power_good),
    .diff_ref_clock_active(diff_ref_clock_active), .hot_reset_active(hot_reset_active));

  // Design under test, with a short training timer
  prc_reset_control #(.TRAIN_LIMIT(TRAIN_LIMIT)) dut (.clock(clock), .reset_n(reset_n),
    .fundamental_reset_n(fundamental_reset_n), .global_reset_n(global_reset_n),
    .power_good(power_good), .diff_ref_clock_active(diff_ref_clock_active),
    .strap_pins(strap_pins), .eeprom_present(eeprom_present),
    .hot_reset_active(hot_reset_active), .link_training(link_training), .wake_oe(wake_oe),
    .eeprom_start(eeprom_start), .eeprom_done(eeprom_done),
    .eeprom_data_valid(eeprom_data_valid), .eeprom_data(eeprom_data),
    .cfg_write(cfg_write), .cfg_read(cfg_read), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .nonsticky_reset(nonsticky_reset),
    .eeprom_class_reset(eeprom_class_reset), .sticky_reset(sticky_reset),
    .pci_bus_reset_n(pci_bus_reset_n), .strap_latched(strap_latched));

  // Verdict and end of run
  task automatic results();
    if (err_count == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Configuration write, one-cycle strobe
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clock);
    cfg_write <= 1'b1;
    cfg_addr <= a;
    cfg_wdata <= d;
    @(posedge clock);
    cfg_write <= 1'b0;
    #1;
  endtask

  // Configuration read, data one cycle after the read edge, then compared
  task automatic rd_chk(input logic [7:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clock);
    cfg_read <= 1'b1;
    cfg_addr <= a;
    @(posedge clock);
    cfg_read <= 1'b0;
    #1;
    `CHK(cfg_rdata & m, e)
  endtask

  // Power-on reset held until the settle time has run out
  task automatic t_por();
    `CHK(pci_bus_reset_n, 1'b0)
    `CHK(wake_oe, 1'b0)
    host.set_global_reset_n(1'b1);
    repeat (90) @(posedge clock);
    #1;
    `CHK(sticky_reset, 1'b1)
    repeat (30) @(posedge clock);
    #1;
    `CHK(sticky_reset, 1'b0)
    `CHK(nonsticky_reset, 1'b1)
    `CHK(pci_bus_reset_n, 1'b0)
    wr(EEPROM_DEFAULTS_OFFSET, 16'hbeef);
    wr(STICKY_SCRATCH_OFFSET, 16'h5a5a);
    rd_chk(EEPROM_DEFAULTS_OFFSET, 16'hffff, 16'h0000);
    rd_chk(BRIDGE_CONTROL_OFFSET, 16'hffff, BRIDGE_CONTROL_RESET);
    rd_chk(8'h50, 16'hffff, 16'h0000);
  endtask

  // Release of fundamental reset: straps latch, download, then training
  task automatic t_release();
    strap_pins <= 4'ha;
    eeprom_present <= 1'b1;
    host.set_fund(1'b1);
    `WAITV(eeprom_start, 1'b1, 10)
    `CHK(eeprom_start, 1'b1)
    `CHK(strap_latched, 4'ha)
    @(posedge clock);
    eeprom_data_valid <= 1'b1;
    eeprom_data <= 16'h1234;
    #1;
    `CHK(eeprom_start, 1'b0)
    `CHK(nonsticky_reset, 1'b0)
    `CHK(link_training, 1'b0)
    @(posedge clock);
    eeprom_data_valid <= 1'b0;
    eeprom_done <= 1'b1;
    strap_pins <= 4'h5;
    @(posedge clock);
    eeprom_done <= 1'b0;
    `WAITV(link_training, 1'b1, 3)
    `CHK(link_training, 1'b1)
    `CHK(strap_latched, 4'ha)
    rd_chk(EEPROM_DEFAULTS_OFFSET, 16'hffff, 16'h1234);
  endtask

  // Software bus reset bit sets and clears the bus reset
  task automatic t_sw();
    `CHK(pci_bus_reset_n, 1'b1)
    wr(BRIDGE_CONTROL_OFFSET, 16'h0040);
    `WAITV(pci_bus_reset_n, 1'b0, 4)
    `CHK(pci_bus_reset_n, 1'b0)
    rd_chk(BRIDGE_CONTROL_OFFSET, 16'hffff, 16'h0040);
    wr(BRIDGE_CONTROL_OFFSET, 16'h0000);
    `WAITV(pci_bus_reset_n, 1'b1, 4)
    `CHK(pci_bus_reset_n, 1'b1)
  endtask

  // Hot reset: DL_DOWN clears ordinary bits, keeps sticky and loadable ones
  task automatic t_hot();
    wr(BRIDGE_CONTROL_OFFSET, 16'h0001);
    host.set_hot(1'b1);
    repeat (3) @(posedge clock);
    #1;
    `CHK({nonsticky_reset, pci_bus_reset_n}, 2'b10)
    `CHK({eeprom_class_reset, sticky_reset}, 2'b00)
    rd_chk(RESET_STATUS_OFFSET, 16'h0003, 16'h0003);
    host.set_hot(1'b0);
    repeat (3) @(posedge clock);
    rd_chk(BRIDGE_CONTROL_OFFSET, 16'hffff, 16'h0000);
    rd_chk(STICKY_SCRATCH_OFFSET, 16'hffff, 16'h5a5a);
    rd_chk(EEPROM_DEFAULTS_OFFSET, 16'hffff, 16'h1234);
    `CHK({link_training, pci_bus_reset_n}, 2'b11)
  endtask

  // Second fundamental reset, training started by the timer alone
  task automatic t_fund();
    host.set_fund(1'b0);
    repeat (6) @(posedge clock);
    #1;
    `CHK({nonsticky_reset, eeprom_class_reset, sticky_reset}, 3'b110)
    `CHK({pci_bus_reset_n, link_training}, 2'b00)
    rd_chk(EEPROM_DEFAULTS_OFFSET, 16'hffff, 16'h0000);
    host.set_fund(1'b1);
    repeat (20) @(posedge clock);
    #1;
    `CHK(link_training, 1'b0)
    `WAITV(link_training, 1'b1, TRAIN_LIMIT)
    `CHK(link_training, 1'b1)
    `CHK(strap_latched, 4'h5)
    rd_chk(STICKY_SCRATCH_OFFSET, 16'hffff, 16'h5a5a);
  endtask

  // Global reset clears sticky bits; power-on waits for supply and reference
  task automatic t_global_reset_n();
    host.set_global_reset_n(1'b0);
    repeat (3) @(posedge clock);
    #1;
    `CHK({sticky_reset, pci_bus_reset_n}, 2'b10)
    host.set_power(1'b0, 1'b0);
    host.set_global_reset_n(1'b1);
    repeat (120) @(posedge clock);
    #1;
    `CHK(sticky_reset, 1'b1)
    host.set_power(1'b1, 1'b0);
    repeat (120) @(posedge clock);
    #1;
    `CHK(sticky_reset, 1'b1)
    host.set_power(1'b1, 1'b1);
    repeat (90) @(posedge clock);
    #1;
    `CHK(sticky_reset, 1'b1)
    repeat (20) @(posedge clock);
    #1;
    `CHK(sticky_reset, 1'b0)
    rd_chk(STICKY_SCRATCH_OFFSET, 16'hffff, 16'h0000);
    eeprom_present <= 1'b0;
    strap_pins <= 4'h3;
    host.set_fund(1'b0);
    repeat (4) @(posedge clock);
    host.set_fund(1'b1);
    repeat (3) @(posedge clock);
    #1;
    `CHK({eeprom_start, strap_latched}, 5'h03)
    @(posedge clock);
    #1;
    `CHK(link_training, 1'b1)
  endtask

  // Main sequence
  initial begin
    strap_pins <= 4'h0;
    eeprom_present <= 1'b0;
    eeprom_done <= 1'b0;
    eeprom_data_valid <= 1'b0;
    eeprom_data <= 16'h0000;
    cfg_write <= 1'b0;
    cfg_read <= 1'b0;
    cfg_addr <= 8'h00;
    cfg_wdata <= 16'h0000;
    repeat (8) @(posedge clock);
    reset_n <= 1'b1;
    t_por();
    t_release();
    t_sw();
    t_hot();
    t_fund();
    t_global_reset_n();
    host.power_down();
    results();
  end

  // Watchdog against a hang
  initial begin
    #1000000;
    err_count++;
    results();
  end
endmodule
